// *** core/ethernet_irq_enable_status.sv ***
`timescale 1ns/1ps
// What this block does
// - enable 15 gates link change
// - enable 14 gates transmit done
// - enable 13 gates frame received
// - enable 11 gates receive overrun
// - enable 9 gates transmit halted
// - enable 8 gates receive halted
// - enable 6 gates transmit space
// - enable 5 gates wake frame
// - enable 4 gates special wake packet
// - enable 3 gates linkup wake
// - enable 2 gates energy wake
// - enable 1 gates host bus error
// - enable 0 delays energy wake until ready
// - irq when any status and enable set
// - status reads have no side effect
// - event edge sets, write one clears
// - link change sets on either transition
// - transmit done sets on sent frame
// - frame received sets on complete frame
// - overrun sets on receive overrun
// - transmit halted sets, resets to one
// - receive halted sets, resets to one
// - bits 15-13, 11, 9, 8, 6 and 1 write-one clear
// - wake bits cleared by one-hot field
// - bit 2 immediate or delayed energy wake
module ethernet_irq_enable_status #(
    parameter logic IRQ_ACTIVE = irq_pkg::IRQ_ACTIVE_LEVEL
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire irq_pkg::reg_req_s REQ_I,
    output logic [15:0] RDATA_O,
    output logic RVALID_O,
    input wire logic PM_CLEAR_WR_I,
    input wire logic [5:2] PM_CLEAR_CODE_I,
    input wire irq_pkg::events_s EVENTS_I,
    output logic [15:0] ENABLE_O,
    output logic [15:0] STATUS_O,
    output logic IRQ_O
);
    localparam int W = irq_pkg::REG_WIDTH;

    logic [W-1:0] enable_reg;
    logic [W-1:0] enable_next;
    logic [W-1:0] status_reg;
    logic [W-1:0] status_next;
    logic [W-1:0] set_vec;
    logic [W-1:0] clr_vec;
    logic [W-1:0] wdata_be;
    logic [W-1:0] be_mask;
    logic irq_reg;
    logic [15:0] rdata_reg;
    logic rvalid_reg;
    logic energy_pending_reg;
    logic [12:0] ev_level;
    logic [12:0] ev_rise;
    logic [12:0] ev_fall;
    logic enable_hit;
    logic status_hit;
    logic [W-1:0] gated;

    // positions of each source inside the packed event vector
    localparam int EV_LINK = 12;
    localparam int EV_TX_DONE = 11;
    localparam int EV_RX_FRAME = 10;
    localparam int EV_RX_OVERRUN = 9;
    localparam int EV_TX_HALTED = 8;
    localparam int EV_RX_HALTED = 7;
    localparam int EV_TX_SPACE = 6;
    localparam int EV_WAKE_FRAME = 5;
    localparam int EV_WAKE_SPECIAL = 4;
    localparam int EV_LINKUP_WAKE = 3;
    localparam int EV_ENERGY = 2;
    localparam int EV_BUS_ERROR = 1;
    localparam int EV_HOST_READY = 0;
    localparam int EV_COUNT = 13;

    // timing as the host sees it:
    // a write strobe lands on the edge that samples it
    // a read answers with data and valid one cycle later
    // an event edge sets its flag on the edge that sees it
    // the pin follows a flag or enable change one cycle later
    // limitation: event levels must already be on this clock,
    // a two-flop stage here would cost two cycles of latency
    // trade-off: edges, not levels, set flags, so a source that
    // stays high after a clear does not set its flag again

    // the field tables only fit a 16-bit register
    if (W != 16) begin : width_check
        $error("register width must be 16");
    end

    // address decode, word address taken on the low byte offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a[7:1] == off[7:1]);
    endfunction : hit

    assign enable_hit = hit(REQ_I.addr, irq_pkg::ENABLE_OFFSET);
    assign status_hit = hit(REQ_I.addr, irq_pkg::STATUS_OFFSET);
    assign be_mask = {{8{REQ_I.be[1]}}, {8{REQ_I.be[0]}}};
    assign wdata_be = REQ_I.wdata & be_mask;

    // event sources; edges found here so a held level sets only once
    assign ev_level = {
        EVENTS_I.link_up,
        EVENTS_I.transmit_done,
        EVENTS_I.receive_frame,
        EVENTS_I.receive_overrun,
        EVENTS_I.transmit_halted,
        EVENTS_I.receive_halted,
        EVENTS_I.transmit_space,
        EVENTS_I.wake_frame,
        EVENTS_I.wake_special,
        EVENTS_I.linkup_wake,
        EVENTS_I.energy_wake,
        EVENTS_I.host_bus_error,
        EVENTS_I.host_ready
    };

    // detectors reset low: a level high at release counts as an edge
    edge_detect #(
        .WIDTH(EV_COUNT),
        .INIT(13'h0000)
    ) u_edges (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .level_i(ev_level),
        .rise_o(ev_rise),
        .fall_o(ev_fall)
    );

    // enable register write with byte enables
    // lanes without their byte enable keep the old byte, and the
    // reserved bits stay zero whatever the host writes
    always_comb begin
        enable_next = enable_reg;
        if (REQ_I.wr && enable_hit) begin
            enable_next = ((enable_reg & ~be_mask) | wdata_be)
                          & irq_pkg::ENABLE_MASK;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            enable_reg <= irq_pkg::ENABLE_RESET;
        end else begin
            enable_reg <= enable_next;
        end
    end

    // delayed energy wake waits here until host access is ready
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            energy_pending_reg <= 1'b0;
        end else if (!enable_reg[irq_pkg::DELAYED_ENERGY_BIT]) begin
            energy_pending_reg <= 1'b0;
        end else if (EVENTS_I.host_ready) begin
            energy_pending_reg <= 1'b0;
        end else if (ev_rise[EV_ENERGY]) begin
            energy_pending_reg <= 1'b1;
        end
    end

    // set vector from event edges, one source per status bit
    always_comb begin
        set_vec = '0;
        // link change on either transition
        set_vec[irq_pkg::LINK_CHANGE_BIT] =
            ev_rise[EV_LINK] | ev_fall[EV_LINK];
        // frame sent and queue has room again
        set_vec[irq_pkg::TRANSMIT_DONE_BIT] =
            ev_rise[EV_TX_DONE];
        // complete frame waiting for the host
        set_vec[irq_pkg::RECEIVE_FRAME_BIT] =
            ev_rise[EV_RX_FRAME];
        // receive path ran out of room
        set_vec[irq_pkg::RECEIVE_OVERRUN_BIT] =
            ev_rise[EV_RX_OVERRUN];
        // transmit process stopped
        set_vec[irq_pkg::TRANSMIT_HALTED_BIT] =
            ev_rise[EV_TX_HALTED];
        // receive process stopped
        set_vec[irq_pkg::RECEIVE_HALTED_BIT] =
            ev_rise[EV_RX_HALTED];
        // transmit buffer space available
        set_vec[irq_pkg::TRANSMIT_SPACE_BIT] =
            ev_rise[EV_TX_SPACE];
        // wake sources, cleared only through the one-hot field
        set_vec[irq_pkg::WAKE_FRAME_BIT] =
            ev_rise[EV_WAKE_FRAME];
        set_vec[irq_pkg::WAKE_SPECIAL_BIT] =
            ev_rise[EV_WAKE_SPECIAL];
        set_vec[irq_pkg::LINKUP_WAKE_BIT] =
            ev_rise[EV_LINKUP_WAKE];
        // immediate when delay off, else once host_ready is high (at once if it already is)
        if (enable_reg[irq_pkg::DELAYED_ENERGY_BIT]) begin
            set_vec[irq_pkg::ENERGY_WAKE_BIT] =
                (energy_pending_reg | ev_rise[EV_ENERGY])
                & EVENTS_I.host_ready;
        end else begin
            set_vec[irq_pkg::ENERGY_WAKE_BIT] =
                ev_rise[EV_ENERGY];
        end
        // serial host port framing error
        set_vec[irq_pkg::HOST_BUS_ERROR_BIT] =
            ev_rise[EV_BUS_ERROR];
    end

    // clear vector: write-one at status, one-hot code for wake bits
    // the wake field lives in another register, so its strobe comes
    // in on its own port; codes with more than one bit clear nothing
    // so a stray multi-bit write cannot wipe several wake flags
    always_comb begin
        clr_vec = '0;
        if (REQ_I.wr && status_hit) begin
            clr_vec = wdata_be & irq_pkg::STATUS_W1C_MASK;
        end
        if (PM_CLEAR_WR_I) begin
            unique case (PM_CLEAR_CODE_I)
                irq_pkg::CLEAR_WAKE_FRAME: begin
                    clr_vec[irq_pkg::WAKE_FRAME_BIT] = 1'b1;
                end
                irq_pkg::CLEAR_WAKE_SPECIAL: begin
                    clr_vec[irq_pkg::WAKE_SPECIAL_BIT] = 1'b1;
                end
                irq_pkg::CLEAR_LINKUP_WAKE: begin
                    clr_vec[irq_pkg::LINKUP_WAKE_BIT] = 1'b1;
                end
                irq_pkg::CLEAR_ENERGY_WAKE: begin
                    clr_vec[irq_pkg::ENERGY_WAKE_BIT] = 1'b1;
                end
                default: begin
                    // other codes clear nothing
                end
            endcase
        end
    end

    // sticky status; set after clear so a coincident event survives
    assign status_next = ((status_reg & ~clr_vec) | set_vec)
                         & irq_pkg::STATUS_MASK;

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            status_reg <= irq_pkg::STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // each bit gated by its own enable
    for (genvar g = 0; g < W; g++) begin : gate_gen
        assign gated[g] = status_reg[g] & enable_reg[g];
    end

    // or-reduced and registered so the pin never glitches
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            irq_reg <= 1'b0;
        end else begin
            // bit 0 is reserved in status so the delay enable adds nothing
            irq_reg <= |gated;
        end
    end
    // per-source gating lives in the and above, bit for bit:

    // read valid, one pulse for each read strobe
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= REQ_I.rd;
        end
    end

    // read data; reads only sample, never clear
    // data holds until the next read so a slow host can still take it
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rdata_reg <= 16'h0000;
        end else begin
            if (REQ_I.rd && enable_hit) begin
                rdata_reg <= enable_reg;
            end else if (REQ_I.rd && status_hit) begin
                rdata_reg <= status_reg;
            end else if (REQ_I.rd) begin
                rdata_reg <= 16'h0000;
            end
        end
    end

    assign RDATA_O = rdata_reg;
    assign RVALID_O = rvalid_reg;
    assign ENABLE_O = enable_reg;
    assign STATUS_O = status_reg;
    // polarity is a parameter since the pin level is not fixed
    assign IRQ_O = IRQ_ACTIVE ? irq_reg : ~irq_reg;
endmodule : ethernet_irq_enable_status

// *** core/irq_pkg.sv ***
package irq_pkg;
    // register offsets, byte addresses of the low byte
    localparam logic [7:0] ENABLE_OFFSET = 8'h90;
    localparam logic [7:0] STATUS_OFFSET = 8'h92;
    localparam int REG_WIDTH = 16;

    // shared field positions of enable and status
    localparam int LINK_CHANGE_BIT = 15;
    localparam int TRANSMIT_DONE_BIT = 14;
    localparam int RECEIVE_FRAME_BIT = 13;
    localparam int RECEIVE_OVERRUN_BIT = 11;
    localparam int TRANSMIT_HALTED_BIT = 9;
    localparam int RECEIVE_HALTED_BIT = 8;
    localparam int TRANSMIT_SPACE_BIT = 6;
    localparam int WAKE_FRAME_BIT = 5;
    localparam int WAKE_SPECIAL_BIT = 4;
    localparam int LINKUP_WAKE_BIT = 3;
    localparam int ENERGY_WAKE_BIT = 2;
    localparam int HOST_BUS_ERROR_BIT = 1;
    localparam int DELAYED_ENERGY_BIT = 0;

    // implemented bits of each register
    localparam logic [15:0] ENABLE_MASK = 16'hEB7F;
    localparam logic [15:0] STATUS_MASK = 16'hEB7E;
    // status bits cleared by write-one at the status register
    localparam logic [15:0] STATUS_W1C_MASK = 16'hEB42;
    // wake bits, cleared through the power-management field
    localparam logic [15:0] STATUS_WAKE_MASK = 16'h003C;

    // reset values
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] STATUS_RESET = 16'h0300;
    localparam logic IRQ_ACTIVE_LEVEL = 1'b0;

    // power-management one-hot clear field position and codes
    localparam int WAKE_CLEAR_LSB = 2;
    localparam logic [3:0] CLEAR_WAKE_FRAME = 4'h8;
    localparam logic [3:0] CLEAR_WAKE_SPECIAL = 4'h4;
    localparam logic [3:0] CLEAR_LINKUP_WAKE = 4'h2;
    localparam logic [3:0] CLEAR_ENERGY_WAKE = 4'h1;

    // host register write strobe with byte enables
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [1:0] be;
        logic [15:0] wdata;
    } reg_req_s;

    // event pulses and levels from the sources
    typedef struct packed {
        logic link_up;
        logic transmit_done;
        logic receive_frame;
        logic receive_overrun;
        logic transmit_halted;
        logic receive_halted;
        logic transmit_space;
        logic wake_frame;
        logic wake_special;
        logic linkup_wake;
        logic energy_wake;
        logic host_bus_error;
        logic host_ready;
    } events_s;
endpackage : irq_pkg

// *** core/edge_detect.sv ***
`timescale 1ns/1ps
// rising- and falling-edge detector over a vector of same-domain levels
module edge_detect #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] level_i,
    output logic [WIDTH-1:0] rise_o,
    output logic [WIDTH-1:0] fall_o
);
    logic [WIDTH-1:0] prev_reg;

    // refused at elaboration, an empty vector has no edges to find
    if (WIDTH < 1) begin : width_check
        $error("edge_detect width must be positive");
    end

    // previous level, reset to INIT, so a level that differs from INIT at release gives an edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_reg <= INIT;
        end else begin
            prev_reg <= level_i;
        end
    end

    assign rise_o = level_i & ~prev_reg;
    assign fall_o = ~level_i & prev_reg;
endmodule : edge_detect

// *** tb/irq_monitor.sv ***
`timescale 1ns/1ps
// watches the top ports only; one clock, one reset
module irq_monitor #(
    parameter logic IRQ_ACTIVE = irq_pkg::IRQ_ACTIVE_LEVEL
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire irq_pkg::reg_req_s REQ_I,
    input wire logic [15:0] RDATA_O,
    input wire logic RVALID_O,
    input wire logic PM_CLEAR_WR_I,
    input wire irq_pkg::events_s EVENTS_I,
    input wire logic [15:0] ENABLE_O,
    input wire logic [15:0] STATUS_O,
    input wire logic IRQ_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    logic st_wr;
    // status word write, address bit 0 ignored
    assign st_wr = REQ_I.wr && REQ_I.addr[7:1] == 7'h49;
    irq_pin_a: assert property (
        IRQ_O == ((|$past(STATUS_O & ENABLE_O)) ~^ IRQ_ACTIVE))
        else $error("irq pin mismatch");
    read_keep_a: assert property (
        REQ_I.rd && !REQ_I.wr && !PM_CLEAR_WR_I
        |=> ($past(STATUS_O) & ~STATUS_O) == 16'h0000)
        else $error("read cleared a status bit");
    read_data_a: assert property (
        REQ_I.rd && !REQ_I.wr && REQ_I.addr[7:1] == 7'h49
        |=> RVALID_O && RDATA_O == $past(STATUS_O))
        else $error("status read data wrong");
    zero_keep_a: assert property (
        !st_wr |=> ($past(STATUS_O) & ~STATUS_O
        & irq_pkg::STATUS_W1C_MASK) == 16'h0000)
        else $error("status bit fell without write");
    wake_keep_a: assert property (
        !PM_CLEAR_WR_I |=> ($past(STATUS_O) & ~STATUS_O
        & irq_pkg::STATUS_WAKE_MASK) == 16'h0000)
        else $error("wake bit fell without code");
    enable_wr_a: assert property (
        REQ_I.wr && REQ_I.addr[7:1] == 7'h48 && REQ_I.be == 2'h3
        |=> ENABLE_O == ($past(REQ_I.wdata) & irq_pkg::ENABLE_MASK))
        else $error("enable write wrong");
    w1c_clear_a: assert property (
        st_wr && REQ_I.be == 2'h3 && EVENTS_I == $past(EVENTS_I)
        |=> (STATUS_O & $past(REQ_I.wdata)
        & irq_pkg::STATUS_W1C_MASK) == 16'h0000)
        else $error("write one did not clear");
    link_edge_a: assert property (
        $changed(EVENTS_I.link_up) |=> STATUS_O[15])
        else $error("link change not flagged");
    delay_hold_a: assert property (
        ENABLE_O[2] && ENABLE_O[0] && !EVENTS_I.host_ready
        && !STATUS_O[2] |=> !STATUS_O[2])
        else $error("delayed energy flag too early");
endmodule : irq_monitor

// *** tb/host_model.sv ***
`timescale 1ns/1ps
// host side; strobes launched 1 ns after the edge, held one cycle
module host_model (
    input wire logic clk_i,
    input wire logic rvalid_i,
    input wire logic [15:0] rdata_i,
    output irq_pkg::reg_req_s req_o,
    output logic pm_wr_o,
    output logic [5:2] pm_code_o
);
    initial begin
        req_o = '0;
        pm_wr_o = 1'h0;
        pm_code_o = 4'h0;
    end
    // full word access; released lines show inverted, not stale
    task automatic access(input logic w, input logic [7:0] a,
        input logic [15:0] d, output logic v, output logic [15:0] q);
        @(posedge clk_i);
        #1;
        req_o = '{wr: w, rd: !w, addr: a, be: 2'h3, wdata: d};
        @(posedge clk_i);
        #1;
        req_o = '{wr: 1'h0, rd: 1'h0, addr: ~a, be: 2'h0, wdata: ~d};
        v = rvalid_i;
        q = rdata_i;
    endtask : access
    // one-hot wake clear strobe
    task automatic pm_clear(input logic [3:0] code);
        @(posedge clk_i);
        #1;
        pm_wr_o = 1'h1;
        pm_code_o = code;
        @(posedge clk_i);
        #1;
        pm_wr_o = 1'h0;
        pm_code_o = ~code;
    endtask : pm_clear
endmodule : host_model

// *** tb/test_ethernet_irq_enable_status.sv ***
`timescale 1ns/1ps
module test_ethernet_irq_enable_status;
    localparam logic OFF = ~irq_pkg::IRQ_ACTIVE_LEVEL;
    logic CLK_I = 1'h0;
    logic RST_N_I = 1'h0;
    irq_pkg::reg_req_s req;
    irq_pkg::events_s evt = '0;
    logic pm_wr;
    logic [3:0] pm_code;
    logic rvalid;
    logic irq;
    logic v;
    logic [15:0] rdata;
    logic [15:0] en;
    logic [15:0] st;
    logic [15:0] q;
    int n_mismatch = 0;
    int num_checks = 0;
    int sb[7] = '{14, 13, 11, 9, 8, 6, 1};
    int eb[7] = '{11, 10, 9, 8, 7, 6, 1};
    always #10 CLK_I = ~CLK_I;
    ethernet_irq_enable_status ethernet_irq_enable_status_inst (
        .CLK_I(CLK_I), .RST_N_I(RST_N_I), .REQ_I(req), .RDATA_O(rdata),
        .RVALID_O(rvalid), .PM_CLEAR_WR_I(pm_wr), .PM_CLEAR_CODE_I(pm_code),
        .EVENTS_I(evt), .ENABLE_O(en), .STATUS_O(st), .IRQ_O(irq));
    host_model host_model_inst (.clk_i(CLK_I), .rvalid_i(rvalid),
        .rdata_i(rdata), .req_o(req), .pm_wr_o(pm_wr), .pm_code_o(pm_code));
    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask : chk16
    task automatic chk_irq(input logic on);
        chk16({15'h0, irq}, {15'h0, on ? irq_pkg::IRQ_ACTIVE_LEVEL : OFF});
    endtask : chk_irq
    task automatic tick();
        @(posedge CLK_I);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host_model_inst.access(1'h1, a, d, v, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        host_model_inst.access(1'h0, a, 16'h0, v, q);
        chk16({15'h0, v}, 16'h1);
        chk16(q, e);
    endtask : rd
    // event level up for one cycle; flag visible on return
    task automatic pulse(input int i);
        tick();
        evt[i] = 1'h1;
        tick();
        evt[i] = 1'h0;
    endtask : pulse
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    // hang guard at 5000 cycles, far beyond the under two hundred cycles the tests need
    initial begin
        #100000;
        n_mismatch++;
        print_verdict();
    end
    initial begin : main
        int i;
        repeat (4) @(posedge CLK_I);
        #1;
        RST_N_I = 1'h1;
        chk16(st, 16'h0300);
        chk16(en, 16'h0000);
        chk_irq(1'h0);
        rd(8'h92, 16'h0300);
        rd(8'hA0, 16'h0000);
        wr(8'h90, 16'hFFFF);
        rd(8'h90, 16'hEB7F);
        wr(8'h92, 16'hFFFF);
        chk16(st, 16'h0000);
        $display("test 1 done");
        for (i = 0; i < 7; i++) begin
            wr(8'h90, ~(16'h1 << sb[i]));
            pulse(eb[i]);
            chk16(st, 16'h1 << sb[i]);
            chk_irq(1'h0);
            wr(8'h90, 16'h1 << sb[i]);
            tick();
            chk_irq(1'h1);
            rd(8'h92, 16'h1 << sb[i]);
            wr(8'h92, ~(16'h1 << sb[i]));
            chk16(st, 16'h1 << sb[i]);
            wr(8'h92, 16'h1 << sb[i]);
            chk16(st, 16'h0000);
            tick();
            chk_irq(1'h0);
        end
        $display("test 2 done");
        // link up then down, each edge flags
        wr(8'h90, 16'h8000);
        evt.link_up = 1'h1;
        tick();
        tick();
        chk16(st, 16'h8000);
        chk_irq(1'h1);
        wr(8'h92, 16'h8000);
        evt.link_up = 1'h0;
        tick();
        tick();
        chk16(st, 16'h8000);
        wr(8'h92, 16'h8000);
        $display("test 3 done");
        // wake flags ignore write-one, only the one-hot code clears
        wr(8'h90, 16'h003C);
        for (i = 0; i < 4; i++) begin
            pulse(5 - i);
            wr(8'h92, 16'hFFFF);
            chk16(st, 16'h0020 >> i);
            chk_irq(1'h1);
            host_model_inst.pm_clear(4'hF);
            chk16(st, 16'h0020 >> i);
            host_model_inst.pm_clear(4'h8 >> i);
            chk16(st, 16'h0000);
        end
        $display("test 4 done");
        // delayed energy waits for host ready
        wr(8'h90, 16'h0005);
        pulse(2);
        repeat (3) tick();
        chk16(st, 16'h0000);
        evt.host_ready = 1'h1;
        tick();
        tick();
        chk16(st, 16'h0004);
        host_model_inst.pm_clear(4'h1);
        $display("test 5 done");
        // clear and new event on the same edge
        pulse(10);
        fork
            wr(8'h92, 16'h2000);
            begin
                tick();
                evt.receive_frame = 1'h1;
            end
        join
        chk16(st, 16'h2000);
        $display("test 6 done");
        print_verdict();
    end
endmodule : test_ethernet_irq_enable_status
bind ethernet_irq_enable_status irq_monitor #(.IRQ_ACTIVE(IRQ_ACTIVE))
    irq_monitor_inst (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .REQ_I(REQ_I),
    .RDATA_O(RDATA_O), .RVALID_O(RVALID_O), .PM_CLEAR_WR_I(PM_CLEAR_WR_I),
    .EVENTS_I(EVENTS_I), .ENABLE_O(ENABLE_O), .STATUS_O(STATUS_O),
    .IRQ_O(IRQ_O));
